/* design/bpc_deadband.v */
/*
 * Complementary pair generator with dead band for half-bridge mode.
 * On every edge of the mark both sides go inactive, wait value x 4 clocks,
 * then the new side turns on. Assumes mark_i is registered, same clock.
 */
`timescale 1ns/1ps
`include "bpc_defs.vh"

module bpc_deadband (
    input wire clk_i,
    input wire rst_i,
    input wire en_i,
    input wire mark_i,
    input wire [6:0] delay_i,
    output reg a_act_o,
    output reg b_act_o
);
    reg cur_ff;
    reg [8:0] cnt_ff;

    always @(posedge clk_i) begin
        if (rst_i || !en_i) begin
            cur_ff <= 1'b0;
            cnt_ff <= 9'h000;
            a_act_o <= 1'b0;
            b_act_o <= 1'b0;
        end else if (mark_i != cur_ff) begin
            // Both off first; never overlap
            cur_ff <= mark_i;
            cnt_ff <= {2'b00, delay_i} << `BPC_DB_SHIFT;
            a_act_o <= 1'b0;
            b_act_o <= 1'b0;
        end else if (cnt_ff != 9'h000) begin
            cnt_ff <= cnt_ff - 9'h001;
        end else begin
            a_act_o <= cur_ff;
            b_act_o <= ~cur_ff;
        end
    end
endmodule

/* design/bpc_defs.vh */
/*
 * Constants of the bridge PWM controller: register map, field positions,
 * reset values, mode and polarity codes, state codes and timing counts.
 * Assumes inclusion by bare name from each design file that needs it.
 */
`ifndef BPC_DEFS_VH
`define BPC_DEFS_VH

// Register word addresses on the plain register port
`define BPC_ADDR_W 4
`define BPC_DATA_W 16
`define BPC_A_CTRL 4'h0
`define BPC_A_SETTING 4'h1
`define BPC_A_PERIOD 4'h2
`define BPC_A_DUTY 4'h3
`define BPC_A_DUTY_UPD 4'h4
`define BPC_A_STATUS 4'h5
`define BPC_A_GPIO_OUT 4'h6
`define BPC_A_GPIO_DIR 4'h7

// Control register fields
`define BPC_CTRL_MODE 1:0
`define BPC_CTRL_POL 3:2
`define BPC_CTRL_PRE 5:4
`define BPC_CTRL_EN 6

// Mode codes
`define BPC_MODE_SINGLE 2'h0
`define BPC_MODE_HALF 2'h1
`define BPC_MODE_FULL_FWD 2'h2
`define BPC_MODE_FULL_REV 2'h3

// Polarity codes: bit 1 set makes A/C active low, bit 0 makes B/D active low
`define BPC_BOTH_PAIRS_ACTIVE_HIGH 2'h0
`define BPC_AC_HIGH_BD_LOW 2'h1
`define BPC_AC_LOW_BD_HIGH 2'h2
`define BPC_BOTH_PAIRS_ACTIVE_LOW 2'h3
`define BPC_POL_AC_LOW_BIT 1
`define BPC_POL_BD_LOW_BIT 0

// Prescale codes and terminal counts
`define BPC_PRESCALE_NONE 2'h0
`define BPC_PRESCALE_BY_FOUR 2'h1
`define BPC_PRESCALE_BY_SIXTEEN 2'h2
`define BPC_PRESCALE_BY_SIXTY_FOUR 2'h3
`define BPC_PRE_LIM_1 6'h00
`define BPC_PRE_LIM_4 6'h03
`define BPC_PRE_LIM_16 6'h0F
`define BPC_PRE_LIM_64 6'h3F

// Field widths
`define BPC_SET_W 7
`define BPC_PER_W 8
`define BPC_DUTY_W 10
`define BPC_DB_CNT_W 9

// Pin masks, bit order D C B A
`define BPC_PINS_NONE 4'h0
`define BPC_PINS_HALF 4'h3
`define BPC_PINS_FULL 4'hF
`define BPC_PIN_A 0
`define BPC_PIN_B 1
`define BPC_PIN_C 2
`define BPC_PIN_D 3

// Period sub-step: four fine steps per period count
`define BPC_SUB_LAST 2'h3
// Dead band unit in oscillator cycles, shift of two gives times four
`define BPC_DB_SHIFT 2

// Controller states
`define BPC_ST_IDLE 2'h0
`define BPC_ST_RUN 2'h1
`define BPC_ST_STOP 2'h2
// Stop hold count; outputs hold inactive level one cycle longer than this before release
`define BPC_STOP_HOLD 4'h4

// Reset values
`define BPC_RST_CTRL 7'h00
`define BPC_RST_SETTING 7'h00
`define BPC_RST_PERIOD 8'h00
`define BPC_RST_DUTY 10'h000
`define BPC_RST_PINS 4'h0

`endif

/* design/bpc_prescale.v */
/*
 * Fine-step enable generator: one-cycle pulse every 1, 4, 16 or 64 clocks.
 * Assumes a single clock domain; restart realigns the divider.
 */
`timescale 1ns/1ps
`include "bpc_defs.vh"

module bpc_prescale (
    input wire clk_i,
    input wire rst_i,
    input wire run_i,
    input wire restart_i,
    input wire [1:0] sel_i,
    output reg tick_o
);
    reg [5:0] cnt_ff;
    reg [5:0] lim;

    always @* begin
        case (sel_i)
            `BPC_PRESCALE_BY_FOUR: lim = `BPC_PRE_LIM_4;
            `BPC_PRESCALE_BY_SIXTEEN: lim = `BPC_PRE_LIM_16;
            `BPC_PRESCALE_BY_SIXTY_FOUR: lim = `BPC_PRE_LIM_64;
            default: lim = `BPC_PRE_LIM_1;
        endcase
    end

    always @(posedge clk_i) begin
        if (rst_i || restart_i || !run_i) begin
            cnt_ff <= 6'h00;
            tick_o <= 1'b0;
        end else if (cnt_ff >= lim) begin
            cnt_ff <= 6'h00;
            tick_o <= 1'b1;
        end else begin
            cnt_ff <= cnt_ff + 6'h01;
            tick_o <= 1'b0;
        end
    end
endmodule

/* design/bpc_top.v */
/*
 * Bridge PWM controller: four-pin PWM with independent, half-bridge and
 * full-bridge modes, polarity per pin pair, prescale and live duty update.
 * Unused pins behave as plain GPIO. Registers sit on a plain port with
 * read data one cycle after the read strobe. Pins are three signals each.
 */
// Summary of operation
// - Pins unused by mode stay plain GPIO
// - Independent mode: mask DCBA enables each pin
// - Independent mode: all enabled pins share waveform
// - Half-bridge: A modulated, B complement, C/D unused
// - Half-bridge dead band 0-127, units four clocks
// - Full forward: A active, D modulated, B/C off
// - Full reverse: C active, B modulated, A/D off
// - Active level selectable per A/C and B/D
// - Start switches used input pins to outputs
// - Duty update keeps timer; full setup restarts it
// - Never run together with standard channel two
// - Mode codes: single, half, forward, reverse
// - Polarity codes 0-3 per pair active levels
// - Eight-bit period sets one full cycle
// - Prescaler divides by 4, 16 or 64
`timescale 1ns/1ps
`include "bpc_defs.vh"

module bpc_top (
    input wire clk_i,
    input wire rst_i,
    input wire [3:0] addr_i,
    input wire [15:0] wr_data_i,
    input wire wr_i,
    input wire rd_i,
    output reg [15:0] rd_data_o,
    input wire ch2_active_i,
    output reg ch2_blocked_o,
    input wire [3:0] pin_in_i,
    output reg [3:0] pin_out_o,
    output reg [3:0] pin_oe_o
);
    // Staged setup fields, committed by a control write with enable
    reg [6:0] ctrl_ff;
    reg [6:0] setting_ff;
    reg [7:0] period_ff;
    reg [9:0] duty_ff;

    // Live configuration used by the running modulator
    reg [1:0] mode_ff;
    reg [1:0] pol_ff;
    reg [1:0] pre_ff;
    reg [6:0] live_set_ff;
    reg [7:0] live_per_ff;
    reg [9:0] live_duty_ff;
    reg [3:0] used_ff;
    reg configured_ff;
    reg refused_ff;

    reg [1:0] state_ff;
    reg [3:0] hold_ff;
    reg restart_ff;

    reg [3:0] gpio_out_ff;
    reg [3:0] gpio_dir_ff;
    reg [3:0] pin_s1_ff;
    reg [3:0] pin_s2_ff;

    reg [1:0] sub_ff;
    reg [7:0] per_cnt_ff;
    reg mark_ff;

    reg [3:0] act;
    reg [3:0] used_new;
    reg [1:0] nxt_state;
    reg [3:0] nxt_hold;
    reg [15:0] rd_mux;

    wire fine_tick;
    wire db_a;
    wire db_b;
    wire running;
    wire ctrl_wr;
    wire start_req;
    wire stop_req;
    wire [9:0] fine_pos;
    wire [3:0] low_active;

    assign running = (state_ff == `BPC_ST_RUN);
    assign ctrl_wr = wr_i && (addr_i == `BPC_A_CTRL);
    // Start refused outright while channel two runs
    assign start_req = ctrl_wr && wr_data_i[`BPC_CTRL_EN] && !ch2_active_i;
    assign stop_req = ctrl_wr && !wr_data_i[`BPC_CTRL_EN];
    assign fine_pos = {per_cnt_ff, sub_ff};

    // Pins used by the mode being started
    always @* begin
        case (wr_data_i[`BPC_CTRL_MODE])
            `BPC_MODE_SINGLE: used_new = setting_ff[3:0];
            `BPC_MODE_HALF: used_new = `BPC_PINS_HALF;
            `BPC_MODE_FULL_FWD: used_new = `BPC_PINS_FULL;
            `BPC_MODE_FULL_REV: used_new = `BPC_PINS_FULL;
            default: used_new = `BPC_PINS_NONE;
        endcase
    end

    // Pin input synchroniser
    always @(posedge clk_i) begin
        if (rst_i) begin
            pin_s1_ff <= `BPC_RST_PINS;
            pin_s2_ff <= `BPC_RST_PINS;
        end else begin
            pin_s1_ff <= pin_in_i;
            pin_s2_ff <= pin_s1_ff;
        end
    end

    // Register writes and setup commit
    always @(posedge clk_i) begin
        if (rst_i) begin
            ctrl_ff <= `BPC_RST_CTRL;
            setting_ff <= `BPC_RST_SETTING;
            period_ff <= `BPC_RST_PERIOD;
            duty_ff <= `BPC_RST_DUTY;
            mode_ff <= `BPC_MODE_SINGLE;
            pol_ff <= `BPC_BOTH_PAIRS_ACTIVE_HIGH;
            pre_ff <= `BPC_PRESCALE_NONE;
            live_set_ff <= `BPC_RST_SETTING;
            live_per_ff <= `BPC_RST_PERIOD;
            live_duty_ff <= `BPC_RST_DUTY;
            used_ff <= `BPC_PINS_NONE;
            configured_ff <= 1'b0;
            refused_ff <= 1'b0;
            restart_ff <= 1'b0;
            gpio_out_ff <= `BPC_RST_PINS;
            gpio_dir_ff <= `BPC_RST_PINS;
        end else begin
            restart_ff <= 1'b0;
            if (wr_i) begin
                case (addr_i)
                    `BPC_A_SETTING: setting_ff <= wr_data_i[6:0];
                    `BPC_A_PERIOD: period_ff <= wr_data_i[7:0];
                    `BPC_A_DUTY: duty_ff <= wr_data_i[9:0];
                    // Ignored until a first setup is accepted
                    `BPC_A_DUTY_UPD: begin
                        if (configured_ff) begin
                            live_duty_ff <= wr_data_i[9:0];
                        end
                    end
                    `BPC_A_GPIO_OUT: gpio_out_ff <= wr_data_i[3:0];
                    `BPC_A_GPIO_DIR: gpio_dir_ff <= wr_data_i[3:0];
                    `BPC_A_CTRL: ctrl_ff <= wr_data_i[6:0];
                    default: ;
                endcase
            end
            if (ctrl_wr && wr_data_i[`BPC_CTRL_EN]) begin
                refused_ff <= ch2_active_i;
            end
            // Full setup: commit staged fields, restart the timer
            if (start_req) begin
                mode_ff <= wr_data_i[`BPC_CTRL_MODE];
                pol_ff <= wr_data_i[`BPC_CTRL_POL];
                pre_ff <= wr_data_i[`BPC_CTRL_PRE];
                live_set_ff <= setting_ff;
                live_per_ff <= period_ff;
                live_duty_ff <= duty_ff;
                used_ff <= used_new;
                configured_ff <= 1'b1;
                restart_ff <= 1'b1;
                gpio_dir_ff <= gpio_dir_ff | used_new;
            end
        end
    end

    // Run state machine
    always @* begin
        nxt_state = state_ff;
        nxt_hold = hold_ff;
        case (state_ff)
            `BPC_ST_IDLE: begin
                if (start_req) begin
                    nxt_state = `BPC_ST_RUN;
                end
            end
            `BPC_ST_RUN: begin
                if (stop_req) begin
                    nxt_state = `BPC_ST_STOP;
                    nxt_hold = `BPC_STOP_HOLD;
                end
            end
            `BPC_ST_STOP: begin
                // New start cuts the inactive hold short
                if (start_req) begin
                    nxt_state = `BPC_ST_RUN;
                end else if (hold_ff == 4'h0) begin
                    nxt_state = `BPC_ST_IDLE;
                end else begin
                    nxt_hold = hold_ff - 4'h1;
                end
            end
            default: nxt_state = `BPC_ST_IDLE;
        endcase
    end

    // Blocked flag follows the next state, so it leads the pins
    always @(posedge clk_i) begin
        if (rst_i) begin
            state_ff <= `BPC_ST_IDLE;
            hold_ff <= 4'h0;
            ch2_blocked_o <= 1'b0;
        end else begin
            state_ff <= nxt_state;
            hold_ff <= nxt_hold;
            ch2_blocked_o <= (nxt_state != `BPC_ST_IDLE);
        end
    end

    // One enable pulse per prescaled clock
    bpc_prescale u_prescale (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .run_i(running),
        .restart_i(restart_ff),
        .sel_i(pre_ff),
        .tick_o(fine_tick)
    );

    // Period timer: sub-step at fine rate, period count at a quarter of it
    always @(posedge clk_i) begin
        if (rst_i || restart_ff || !running) begin
            sub_ff <= 2'h0;
            per_cnt_ff <= 8'h00;
        end else if (fine_tick) begin
            if (sub_ff == `BPC_SUB_LAST) begin
                sub_ff <= 2'h0;
                if (per_cnt_ff >= live_per_ff) begin
                    per_cnt_ff <= 8'h00;
                end else begin
                    per_cnt_ff <= per_cnt_ff + 8'h01;
                end
            end else begin
                sub_ff <= sub_ff + 2'h1;
            end
        end
    end

    // Mark compare at fine resolution
    // Registered so the dead band sees clean edges
    always @(posedge clk_i) begin
        if (rst_i || !running) begin
            mark_ff <= 1'b0;
        end else begin
            mark_ff <= (fine_pos < live_duty_ff);
        end
    end

    // Pair generator runs only in half-bridge mode
    bpc_deadband u_deadband (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .en_i(running && (mode_ff == `BPC_MODE_HALF)),
        .mark_i(mark_ff),
        .delay_i(live_set_ff),
        .a_act_o(db_a),
        .b_act_o(db_b)
    );

    // Active state per pin, bit order D C B A
    always @* begin
        act = 4'h0;
        // Idle and stop leave every pin inactive
        if (running) begin
            case (mode_ff)
                `BPC_MODE_SINGLE: act = live_set_ff[3:0] & {4{mark_ff}};
                `BPC_MODE_HALF: begin
                    act[`BPC_PIN_A] = db_a;
                    act[`BPC_PIN_B] = db_b;
                end
                `BPC_MODE_FULL_FWD: begin
                    act[`BPC_PIN_A] = 1'b1;
                    act[`BPC_PIN_D] = mark_ff;
                end
                `BPC_MODE_FULL_REV: begin
                    act[`BPC_PIN_C] = 1'b1;
                    act[`BPC_PIN_B] = mark_ff;
                end
                default: act = 4'h0;
            endcase
        end
    end

    // Pair polarity: A/C follow one bit, B/D the other
    assign low_active = {pol_ff[`BPC_POL_BD_LOW_BIT], pol_ff[`BPC_POL_AC_LOW_BIT],
                         pol_ff[`BPC_POL_BD_LOW_BIT], pol_ff[`BPC_POL_AC_LOW_BIT]};

    // Pins not held by the modulator fall back to GPIO registers
    genvar gi;
    generate
        for (gi = 0; gi < 4; gi = gi + 1) begin : g_pin
            always @(posedge clk_i) begin
                if (rst_i) begin
                    pin_out_o[gi] <= 1'b0;
                    pin_oe_o[gi] <= 1'b0;
                end else if ((state_ff != `BPC_ST_IDLE) && used_ff[gi]) begin
                    // Stop state leaves act low: inactive level held
                    pin_out_o[gi] <= act[gi] ^ low_active[gi];
                    pin_oe_o[gi] <= 1'b1;
                end else begin
                    pin_out_o[gi] <= gpio_out_ff[gi];
                    pin_oe_o[gi] <= gpio_dir_ff[gi];
                end
            end
        end
    endgenerate

    // Read mux
    always @* begin
        rd_mux = 16'h0000;
        case (addr_i)
            `BPC_A_CTRL: rd_mux = {9'h000, ctrl_ff};
            `BPC_A_SETTING: rd_mux = {9'h000, setting_ff};
            `BPC_A_PERIOD: rd_mux = {8'h00, period_ff};
            `BPC_A_DUTY: rd_mux = {6'h00, duty_ff};
            `BPC_A_DUTY_UPD: rd_mux = {6'h00, live_duty_ff};
            `BPC_A_STATUS: rd_mux = {3'h0, mark_ff, refused_ff, configured_ff,
                                     state_ff, pin_oe_o, pin_s2_ff};
            `BPC_A_GPIO_OUT: rd_mux = {12'h000, gpio_out_ff};
            `BPC_A_GPIO_DIR: rd_mux = {12'h000, gpio_dir_ff};
            default: rd_mux = 16'h0000;
        endcase
    end

    // Read data stand one cycle, zero otherwise
    always @(posedge clk_i) begin
        if (rst_i) begin
            rd_data_o <= 16'h0000;
        end else if (rd_i) begin
            rd_data_o <= rd_mux;
        end else begin
            rd_data_o <= 16'h0000;
        end
    end
endmodule

/* test/bpc_fet_stage.sv */
/*
 * Bridge driver stage model: resolves pin levels through pull resistors.
 * Assumes pull_up_i set per pin to suit the chosen active level.
 */
`timescale 1ns/1ps
module bpc_fet_stage (
    input wire [3:0] pin_out_i,
    input wire [3:0] pin_oe_i,
    input wire [3:0] pull_up_i,
    output wire [3:0] level_o,
    output wire shoot_o
);
    // Undriven pin rests at its resistor level
    assign level_o = (pin_oe_i & pin_out_i) | (~pin_oe_i & pull_up_i);
    wire [3:0] on = level_o ^ pull_up_i;
    // Both legs of one side on shorts the supply
    assign shoot_o = (on[0] & on[1]) | (on[2] & on[3]);
endmodule

/* test/bpc_top_asserts.sv */
/*
 * Port checker for bpc_top.
 * Assumes binding to bpc_top, one clock domain.
 */
`timescale 1ns/1ps
module bpc_top_asserts (
    input wire clk_i,
    input wire rst_i,
    input wire [3:0] addr_i,
    input wire [15:0] wr_data_i,
    input wire wr_i,
    input wire rd_i,
    input wire [15:0] rd_data_o,
    input wire ch2_active_i,
    input wire ch2_blocked_o,
    input wire [3:0] pin_in_i,
    input wire [3:0] pin_out_o,
    input wire [3:0] pin_oe_o
);
    reg [6:0] ctl_ff;
    reg [3:0] set_ff;
    reg [3:0] msk_ff;
    reg [3:0] cnt_ff;
    wire ctl_wr = wr_i && addr_i == 4'h0;
    wire go = ctl_wr && !(wr_data_i[6] && ch2_active_i);
    wire run = ctl_ff[6] && &cnt_ff;
    wire [1:0] md = ctl_ff[1:0];
    wire [3:0] act = pin_out_o ^ {ctl_ff[2], ctl_ff[3], ctl_ff[2], ctl_ff[3]};
    wire [3:0] used = md == 2'h0 ? msk_ff : (md == 2'h1 ? 4'h3 : 4'hF);
    wire stop = ctl_wr && !wr_data_i[6] && ch2_blocked_o;
    always @(posedge clk_i) begin
        if (rst_i) begin
            ctl_ff <= 7'h00;
            set_ff <= 4'h0;
            msk_ff <= 4'h0;
            cnt_ff <= 4'h0;
        end else begin
            if (wr_i && addr_i == 4'h1) set_ff <= wr_data_i[3:0];
            if (go) ctl_ff <= wr_data_i[6:0];
            if (go && wr_data_i[6]) msk_ff <= set_ff;
            cnt_ff <= go ? 4'h0 : cnt_ff + {3'h0, ~&cnt_ff};
        end
    end
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    a_read_idle_zero: assert property (!rd_i |=> rd_data_o == 16'h0000)
        else $error("read data not zero");
    a_unmapped_read: assert property (rd_i && addr_i[3] |=> rd_data_o == 16'h0000)
        else $error("unmapped read not zero");
    a_start_blocks_ch2: assert property (go && wr_data_i[6] |=> ##1 ch2_blocked_o)
        else $error("start did not block channel two");
    a_refused_start: assert property (ctl_wr && wr_data_i[6] && ch2_active_i
        && !ch2_blocked_o |=> ##1 !ch2_blocked_o) else $error("start not refused");
    a_stop_release: assert property (stop |=> ch2_blocked_o [*4] ##[1:6] !ch2_blocked_o)
        else $error("stop hold wrong");
    a_stop_inactive: assert property (stop |=> ##2 (act & used) == 4'h0
        && (pin_oe_o & used) == used) else $error("stop level wrong");
    a_used_driven: assert property (run |-> (pin_oe_o & used) == used)
        else $error("used pin not driven");
    a_single_same: assert property (run && md == 2'h0 |->
        (act & used) == used || (act & used) == 4'h0) else $error("pins differ");
    a_half_exclusive: assert property (run && md == 2'h1 |-> !(act[0] && act[1]))
        else $error("both half pins active");
    a_fwd_hold: assert property (run && md == 2'h2 |-> act[0] && !act[1] && !act[2])
        else $error("forward levels wrong");
    a_rev_hold: assert property (run && md == 2'h3 |-> act[2] && !act[0] && !act[3])
        else $error("reverse levels wrong");
endmodule
bind bpc_top bpc_top_asserts i_bpc_top_asserts (.clk_i(clk_i), .rst_i(rst_i),
    .addr_i(addr_i), .wr_data_i(wr_data_i), .wr_i(wr_i), .rd_i(rd_i),
    .rd_data_o(rd_data_o), .ch2_active_i(ch2_active_i), .ch2_blocked_o(ch2_blocked_o),
    .pin_in_i(pin_in_i), .pin_out_o(pin_out_o), .pin_oe_o(pin_oe_o));

/* test/bpc_top_bench.sv */
/*
 * Bench for bpc_top: register tasks, pin duty measurement.
 * Assumes the driver stage model feeds pin levels back.
 */
`timescale 1ns/1ps
module bpc_top_bench;
    reg clk_i = 1'b0;
    reg rst_i = 1'b1;
    reg [3:0] addr_i = 4'h0;
    reg [15:0] wr_data_i = 16'h0000;
    reg wr_i = 1'b0;
    reg rd_i = 1'b0;
    reg ch2_active_i = 1'b0;
    reg [3:0] lo = 4'h0;
    reg [15:0] v;
    reg [15:0] cw;
    reg [15:0] mt = 16'hF618;
    reg [7:0] kt = 8'h13;
    wire [15:0] rd_data_o;
    wire ch2_blocked_o;
    wire [3:0] lvl;
    wire [3:0] pin_out_o;
    wire [3:0] pin_oe_o;
    wire shoot;
    integer fails = 0;
    integer check_count = 0;
    integer i;
    integer n;
    integer sc;
    initial forever #5 clk_i = ~clk_i;
    bpc_top i_bpc_top (.clk_i(clk_i), .rst_i(rst_i), .addr_i(addr_i),
        .wr_data_i(wr_data_i), .wr_i(wr_i), .rd_i(rd_i), .rd_data_o(rd_data_o),
        .ch2_active_i(ch2_active_i), .ch2_blocked_o(ch2_blocked_o),
        .pin_in_i(lvl), .pin_out_o(pin_out_o), .pin_oe_o(pin_oe_o));
    bpc_fet_stage i_bpc_fet_stage (.pin_out_i(pin_out_o), .pin_oe_i(pin_oe_o),
        .pull_up_i(lo), .level_o(lvl), .shoot_o(shoot));
    task chk(input [127:0] nm, input [15:0] e, input [15:0] g);
        begin
            check_count = check_count + 1;
            if (g !== e) begin
                fails = fails + 1;
                $display("[FAIL] %0s expected %h seen %h", nm, e, g);
            end
        end
    endtask
    task final_report;
        begin
            $display("checks %0d mismatches %0d", check_count, fails);
            if (fails == 0 && check_count > 0)
                $display("ALL CHECKS OK");
            else
                $display("CHECKS NOT OK");
            $finish;
        end
    endtask
    task wr(input [3:0] a, input [15:0] d);
        begin
            @(posedge clk_i);
            wr_i <= 1'b1;
            addr_i <= a;
            wr_data_i <= d;
            @(posedge clk_i);
            wr_i <= 1'b0;
        end
    endtask
    task rd(input [3:0] a);
        begin
            @(posedge clk_i);
            rd_i <= 1'b1;
            addr_i <= a;
            @(posedge clk_i);
            rd_i <= 1'b0;
            #1 v = rd_data_o;
        end
    endtask
    task meas(input integer k, input integer len);
        begin
            n = 0;
            repeat (len) begin
                @(posedge clk_i);
                #1 n = n + ((pin_out_o[k] ^ lo[k]) === 1'b1);
                sc = sc + (shoot === 1'b1);
            end
        end
    endtask
    task go(input [1:0] m, input [1:0] p, input [1:0] s, input [6:0] st,
        input [7:0] pr, input [9:0] d);
        begin
            lo = {p[0], p[1], p[0], p[1]};
            cw = {9'h0, 1'b1, s, p, m};
            wr(4'h1, {9'h0, st});
            wr(4'h2, {8'h0, pr});
            wr(4'h3, {6'h0, d});
            wr(4'h0, cw);
            repeat (20) @(posedge clk_i);
            #1;
        end
    endtask
    task stop;
        begin
            wr(4'h0, {9'h0, 1'b0, cw[5:0]});
            repeat (12) @(posedge clk_i);
            #1 chk("released", 16'h0, {15'h0, ch2_blocked_o});
        end
    endtask
    initial begin
        repeat (100000) @(posedge clk_i);
        fails = fails + 1;
        $display("[FAIL] run time expected end seen none");
        final_report;
    end
    initial begin
        repeat (8) @(posedge clk_i);
        rst_i <= 1'b0;
        for (i = 0; i < 9; i = i + 1) begin
            rd(i == 8 ? 4'hC : i[3:0]);
            chk("reset value", 16'h0000, v);
        end
        wr(4'hC, 16'hFFFF);
        rd(4'hC);
        chk("unmapped", 16'h0000, v);
        wr(4'h4, 16'h0005);
        rd(4'h4);
        chk("early duty", 16'h0000, v);
        // Single mode: every polarity and prescale, mark over one period
        for (i = 0; i < 4; i = i + 1) begin
            go(2'h0, i[1:0], i[1:0], {3'h0, mt[i*4 +: 4]}, 8'h03, 10'h006);
            chk("oe mask", {12'h0, mt[i*4 +: 4]}, {12'h0, pin_oe_o & mt[i*4 +: 4]});
            meas(kt[i*2 +: 2], 16 << (2 * i));
            chk("mark", 6 << (2 * i), n[15:0]);
            wr(4'h4, 16'h0009);
            repeat (16 << (2 * i)) @(posedge clk_i);
            meas(kt[i*2 +: 2], 16 << (2 * i));
            chk("updated mark", 9 << (2 * i), n[15:0]);
            rd(4'h4);
            chk("live duty", 16'h0009, v);
            stop;
        end
        sc = 0;
        wr(4'h6, 16'h0004);
        wr(4'h7, 16'h000C);
        go(2'h1, 2'h0, 2'h0, 7'h02, 8'h0F, 10'h028);
        meas(0, 64);
        chk("half a", 16'd31, n[15:0]);
        meas(1, 64);
        chk("half b", 16'd15, n[15:0]);
        chk("gpio pins", 16'h000D, {12'h0, pin_oe_o[3:2], pin_out_o[3:2]});
        rd(4'h5);
        chk("pin sense", 16'h0001, {14'h0, v[3:2]});
        stop;
        for (i = 0; i < 2; i = i + 1) begin
            go({1'b1, i[0]}, 2'h1, 2'h0, 7'h00, 8'h03, 10'h006);
            meas(i ? 2 : 0, 16);
            chk("held pin", 16'd16, n[15:0]);
            meas(i ? 1 : 3, 16);
            chk("mod pin", 16'd6, n[15:0]);
            stop;
        end
        chk("shoot", 16'h0, sc[15:0]);
        @(posedge clk_i);
        ch2_active_i <= 1'b1;
        go(2'h0, 2'h0, 2'h0, 7'h01, 8'h03, 10'h006);
        chk("refused", 16'h0, {15'h0, ch2_blocked_o});
        rd(4'h5);
        chk("refused bit", 16'h1, {15'h0, v[11]});
        @(posedge clk_i);
        ch2_active_i <= 1'b0;
        wr(4'h0, cw);
        repeat (3) @(posedge clk_i);
        #1 chk("blocked", 16'h1, {15'h0, ch2_blocked_o});
        stop;
        final_report;
    end
endmodule
